// >>> core/sebw_pkg.sv
`default_nettype none
package sebw_pkg;
   // Bus clock period and the self-timed programming interval.
   localparam int CLK_PERIOD_NS             = 4;
   localparam int INTERNAL_PROGRAM_TIME_NS  = 100000;
   localparam int PROG_CYCLES_DEF           = (INTERNAL_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Select byte layout.
   localparam logic [3:0] TYPE_ARRAY        = 4'hA;
   localparam logic [3:0] TYPE_ID_PAGE      = 4'hB;
   localparam int TYPE_MSB                  = 7;
   localparam int TYPE_LSB                  = 4;
   localparam int CS_MSB                    = 3;
   localparam int CS_LSB                    = 1;
   localparam int RW_POS                    = 0;
   // Address layout.
   localparam int ADDR_W                    = 16;
   localparam int OFS_W                     = 6;
   localparam int ID_LOCK_SEL_BIT           = 10;
   localparam int ARRAY_MSB                 = 13;
   localparam int LOCK_DATA_BIT             = 1;
   localparam int PAGE_BYTES                = 64;
   // Four-byte correction groups.
   localparam int GRP_BYTES                 = 4;
   localparam int NUM_GRPS                  = 16;
   localparam int GRP_W                     = 12;
   localparam int FIFO_DEPTH                = 16;
   localparam int FIFO_W                    = 1 + GRP_W + 8 * GRP_BYTES + GRP_BYTES;
   // Bit slot index of the acknowledge.
   localparam logic [3:0] ACK_SLOT          = 4'h8;
   // Synchronised pins: index and reset level.
   localparam int SYNC_N                    = 6;
   localparam int PIN_SCL                   = 0;
   localparam int PIN_SDA                   = 1;
   localparam int PIN_CS_LO                 = 2;
   localparam int PIN_CS_MID                = 3;
   localparam int PIN_CS_HI                 = 4;
   localparam int PIN_WP                    = 5;
   localparam logic [SYNC_N-1:0] PIN_RST    = 6'h03;
   typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_ADDR_HI, ST_ADDR_LO, ST_DATA, ST_BUSY} sebw_state_t;
endpackage
`default_nettype wire

// >>> core/sebw_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sebw_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   // Fill side.
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // Drain side.
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0]   count_reg;
   logic          push;
   logic          pop;

   // Full and empty come straight from the occupancy count.
   assign in_ready_o  = (count_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid_o = (count_reg != '0);
   assign out_data_o  = mem_reg[rd_ptr_reg];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // Storage is written only on an accepted push.
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   // Pointers wrap at the depth, which is a power of two.
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// >>> core/sebw_slave.sv
// Operation
// - Start: SDA falls while SCL high.
// - Watch for Start except while programming.
// - Stop: SDA rises while SCL high; ends.
// - Sample SDA on each rising SCL edge.
// - Receiver pulls SDA low in ninth clock.
// - Select bits 3..1 must equal straps.
// - Select bit 0: one read, zero write.
// - Match acks; mismatch releases, goes standby.
// - Write select, then two acked address bytes.
// - Program only on Stop in slot ten.
// - Counter points past last modified byte.
// - While programming, SDA released, requests ignored.
// - Protect high: data not acked, no write.
// - Page write wraps within 64-byte page.
// - Each data byte bumps low six bits; refused bytes and lock-command bytes do not.
// - Identification write: bit ten zero, offset.
// - Locked page: identification data not acked.
// - Lock command locks when data bit one.
// - Writes reprogram whole aligned four-byte group.
// - Protect low or floating allows writes.
// - Floating strap reads as zero.
// - Start mid-instruction aborts pending command.
`timescale 1ns/100ps
`default_nettype none
module sebw_slave #(
   parameter int PROG_CYCLES = sebw_pkg::PROG_CYCLES_DEF
) (
   // Clock and reset.
   input  wire logic                        clk_i,
   input  wire logic                        reset_i,
   // Two-wire bus pins.
   input  wire logic                        scl_i,
   input  wire logic                        sda_i,
   output logic                             sda_o,
   output logic                             sda_oe_n_o,
   // Straps and protection.
   input  wire logic                        chip_select_strap_hi_i,
   input  wire logic                        chip_select_strap_mid_i,
   input  wire logic                        chip_select_strap_lo_i,
   input  wire logic                        write_protect_input_i,
   // Program port toward the cell array.
   output logic                             prog_valid_o,
   input  wire logic                        prog_ready_i,
   output logic                             prog_id_page_o,
   output logic [sebw_pkg::GRP_W-1:0]       prog_group_o,
   output logic [8*sebw_pkg::GRP_BYTES-1:0] prog_data_o,
   output logic [sebw_pkg::GRP_BYTES-1:0]   prog_mask_o,
   // Status.
   output logic                             busy_o,
   output logic                             id_locked_o,
   output logic [sebw_pkg::ADDR_W-1:0]      addr_counter_o
);
   import sebw_pkg::*;

   logic [SYNC_N-1:0] pin_raw;
   logic [SYNC_N-1:0] s1_reg, s2_reg, s3_reg, filt_reg, prev_reg;
   logic              scl_rise, scl_fall, start_seen, stop_seen;
   sebw_state_t       st_reg;
   logic [3:0]        bitcnt_reg;
   logic [7:0]        shift_reg;
   logic              in_ack_reg, data_acked_reg, id_sel_reg, lock_pend_reg, id_locked_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [7:0]        page_reg [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] mask_reg;
   logic              take, dev_match, lock_cmd, data_ok, ack_ok, store, commit, eng_done;
   logic              push_reg;
   logic [3:0]        grp_reg;
   logic [31:0]       timer_reg;
   logic              fifo_in_ready, fifo_out_valid, fifo_out_ready, grp_dirty;
   logic [FIFO_W-1:0] fifo_in, fifo_out;
   logic [8*GRP_BYTES-1:0] grp_data;

   ////////////////////////////////////////////////////////////////////////////
   // Floating straps and a floating protect input are pulled low on the pad.
   assign pin_raw = {write_protect_input_i, chip_select_strap_hi_i,
                     chip_select_strap_mid_i, chip_select_strap_lo_i, sda_i, scl_i};

   // Each pin passes three flops; a change counts once the last two agree.
   for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
      always_ff @(posedge clk_i or posedge reset_i) begin
         if (reset_i) begin
            s1_reg[g]   <= PIN_RST[g];
            s2_reg[g]   <= PIN_RST[g];
            s3_reg[g]   <= PIN_RST[g];
            filt_reg[g] <= PIN_RST[g];
            prev_reg[g] <= PIN_RST[g];
         end else begin
            s1_reg[g]   <= pin_raw[g];
            s2_reg[g]   <= s1_reg[g];
            s3_reg[g]   <= s2_reg[g];
            filt_reg[g] <= (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : filt_reg[g];
            prev_reg[g] <= filt_reg[g];
         end
      end
   end

   // Bus events from the filtered levels; Start and Stop need SCL high on both sides.
   assign scl_rise   = filt_reg[PIN_SCL] && !prev_reg[PIN_SCL];
   assign scl_fall   = !filt_reg[PIN_SCL] && prev_reg[PIN_SCL];
   assign start_seen = !filt_reg[PIN_SDA] && prev_reg[PIN_SDA] && filt_reg[PIN_SCL] && prev_reg[PIN_SCL];
   assign stop_seen  = filt_reg[PIN_SDA] && !prev_reg[PIN_SDA] && filt_reg[PIN_SCL] && prev_reg[PIN_SCL];

   ////////////////////////////////////////////////////////////////////////////
   // Byte decisions are taken on the SCL fall after the eighth bit.
   assign take      = scl_fall && (bitcnt_reg == ACK_SLOT) && !in_ack_reg;
   assign dev_match = (shift_reg[TYPE_MSB:TYPE_LSB] == TYPE_ARRAY ||
                       shift_reg[TYPE_MSB:TYPE_LSB] == TYPE_ID_PAGE) &&
                      (shift_reg[CS_MSB:CS_LSB] == {filt_reg[PIN_CS_HI], filt_reg[PIN_CS_MID],
                                                    filt_reg[PIN_CS_LO]});
   assign lock_cmd  = id_sel_reg && addr_reg[ID_LOCK_SEL_BIT];
   assign data_ok   = !filt_reg[PIN_WP] && !(id_sel_reg && id_locked_reg);
   assign store     = take && (st_reg == ST_DATA) && data_ok && !lock_cmd;
   assign commit    = stop_seen && (st_reg == ST_DATA) && (bitcnt_reg == 4'h1) &&
                      data_acked_reg && !filt_reg[PIN_WP];

   // Acknowledge choice per phase of the instruction.
   always_comb begin
      unique case (st_reg)
         ST_DEV:                 ack_ok = dev_match;
         ST_ADDR_HI, ST_ADDR_LO: ack_ok = 1'b1;
         ST_DATA:                ack_ok = data_ok;
         default:                ack_ok = 1'b0;
      endcase
   end

   // Protocol sequencer, bit counter, shifter and open-drain drive.
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_reg         <= ST_IDLE;
         bitcnt_reg     <= 4'h0;
         shift_reg      <= 8'h00;
         in_ack_reg     <= 1'b0;
         sda_oe_n_o     <= 1'b1;
         data_acked_reg <= 1'b0;
         id_sel_reg     <= 1'b0;
         addr_reg       <= 16'h0000;
         lock_pend_reg  <= 1'b0;
         id_locked_reg  <= 1'b0;
      end else if (st_reg == ST_BUSY) begin
         sda_oe_n_o <= 1'b1;
         in_ack_reg <= 1'b0;
         if (eng_done) begin
            st_reg <= ST_IDLE;
         end
      end else if (start_seen) begin
         st_reg         <= ST_DEV;
         bitcnt_reg     <= 4'h0;
         in_ack_reg     <= 1'b0;
         sda_oe_n_o     <= 1'b1;
         data_acked_reg <= 1'b0;
         lock_pend_reg  <= 1'b0;
      end else if (stop_seen) begin
         sda_oe_n_o <= 1'b1;
         in_ack_reg <= 1'b0;
         bitcnt_reg <= 4'h0;
         st_reg     <= commit ? ST_BUSY : ST_IDLE;
         if (commit && lock_pend_reg) begin
            id_locked_reg <= 1'b1;
         end
      end else if (scl_rise && st_reg != ST_IDLE && bitcnt_reg != ACK_SLOT) begin
         shift_reg  <= {shift_reg[6:0], filt_reg[PIN_SDA]};
         bitcnt_reg <= bitcnt_reg + 4'h1;
         if (bitcnt_reg == 4'h1) begin
            data_acked_reg <= 1'b0;
         end
      end else if (take && st_reg != ST_IDLE) begin
         in_ack_reg     <= 1'b1;
         sda_oe_n_o     <= !ack_ok;
         data_acked_reg <= (st_reg == ST_DATA) && data_ok;
         unique case (st_reg)
            ST_DEV: begin
               id_sel_reg <= (shift_reg[TYPE_MSB:TYPE_LSB] == TYPE_ID_PAGE);
               // Read sequences live elsewhere; a read select is acked and left.
               st_reg <= (dev_match && !shift_reg[RW_POS]) ? ST_ADDR_HI : ST_IDLE;
            end
            ST_ADDR_HI: begin
               addr_reg[15:8] <= shift_reg;
               st_reg         <= ST_ADDR_LO;
            end
            ST_ADDR_LO: begin
               addr_reg[7:0] <= shift_reg;
               st_reg        <= ST_DATA;
            end
            default: begin
               if (data_ok && lock_cmd) begin
                  lock_pend_reg <= shift_reg[LOCK_DATA_BIT];
               end else if (data_ok) begin
                  addr_reg[OFS_W-1:0] <= addr_reg[OFS_W-1:0] + 6'h01;
               end
            end
         endcase
      end else if (scl_fall && in_ack_reg) begin
         in_ack_reg <= 1'b0;
         sda_oe_n_o <= 1'b1;
         bitcnt_reg <= 4'h0;
      end
   end

   // The data pin is only ever pulled low.
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Page latch: bytes are held until a valid Stop, so an aborted command leaves no trace.
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         mask_reg <= '0;
      end else if (start_seen && st_reg != ST_BUSY) begin
         mask_reg <= '0;
      end else if (eng_done) begin
         mask_reg <= '0;
      end else if (store) begin
         mask_reg[addr_reg[OFS_W-1:0]] <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (store) begin
         page_reg[addr_reg[OFS_W-1:0]] <= shift_reg;
      end
   end

   // One group of four bytes with its byte mask; the array merges unmasked bytes.
   assign grp_dirty = |mask_reg[{grp_reg, 2'b00} +: GRP_BYTES];
   for (genvar b = 0; b < GRP_BYTES; b++) begin : g_grp
      assign grp_data[8*b +: 8] = page_reg[{grp_reg, 2'(b)}];
   end
   assign fifo_in = {id_sel_reg,
                     id_sel_reg ? {8'h00, grp_reg} : {addr_reg[ARRAY_MSB:OFS_W], grp_reg},
                     grp_data, mask_reg[{grp_reg, 2'b00} +: GRP_BYTES]};

   ////////////////////////////////////////////////////////////////////////////
   // Programming engine: walk the groups while the programming time runs out; done when both finish.
   // A stalled array port holds the engine once the FIFO is full, so busy can outlast the timer.
   assign eng_done = (st_reg == ST_BUSY) && !push_reg && (timer_reg == 32'h0);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         push_reg  <= 1'b0;
         grp_reg   <= 4'h0;
         timer_reg <= 32'h0;
      end else if (commit) begin
         push_reg  <= !lock_cmd;
         grp_reg   <= 4'h0;
         timer_reg <= 32'(PROG_CYCLES);
      end else begin
         if (timer_reg != 32'h0) begin
            timer_reg <= timer_reg - 32'h1;
         end
         if (push_reg && (!grp_dirty || fifo_in_ready)) begin
            grp_reg <= grp_reg + 4'h1;
            if (grp_reg == 4'(NUM_GRPS - 1)) begin
               push_reg <= 1'b0;
            end
         end
      end
   end

   sebw_fifo #(
      .W     (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .in_valid_i  (push_reg && grp_dirty),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (fifo_in),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_out_ready),
      .out_data_o  (fifo_out)
   );

   // Output stage keeps the program port registered.
   assign fifo_out_ready = !prog_valid_o || prog_ready_i;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         prog_valid_o   <= 1'b0;
         prog_id_page_o <= 1'b0;
         prog_group_o   <= '0;
         prog_data_o    <= '0;
         prog_mask_o    <= '0;
      end else if (fifo_out_ready) begin
         prog_valid_o <= fifo_out_valid;
         {prog_id_page_o, prog_group_o, prog_data_o, prog_mask_o} <= fifo_out;
      end
   end

   // Status mirrors.
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_o         <= 1'b0;
         id_locked_o    <= 1'b0;
         addr_counter_o <= 16'h0000;
      end else begin
         busy_o         <= (st_reg == ST_BUSY);
         id_locked_o    <= id_locked_reg;
         addr_counter_o <= addr_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence s_acked;
      take && ack_ok ##1 !sda_oe_n_o;
   endsequence

   a_busy_released: assert property (st_reg == ST_BUSY |=> sda_oe_n_o)
      else $error("data pin driven while programming");
   a_busy_ignores_start: assert property (st_reg == ST_BUSY && start_seen && !eng_done |=> st_reg == ST_BUSY)
      else $error("start taken while programming");
   a_commit_slot_ten: assert property ($rose(st_reg == ST_BUSY) |-> $past(bitcnt_reg) == 4'h1 && $past(data_acked_reg))
      else $error("programming started outside slot ten");
   a_ack_held: assert property (s_acked |-> !sda_oe_n_o until scl_fall)
      else $error("acknowledge dropped before clock fall");
   a_mismatch_idle: assert property (take && st_reg == ST_DEV && !dev_match |=> st_reg == ST_IDLE && sda_oe_n_o)
      else $error("mismatched select acknowledged");
   a_wp_no_ack: assert property (take && st_reg == ST_DATA && filt_reg[PIN_WP] |=> sda_oe_n_o [*2])
      else $error("data acked under write protect");
   a_locked_no_ack: assert property (take && st_reg == ST_DATA && id_sel_reg && id_locked_reg |=> sda_oe_n_o)
      else $error("locked page data acknowledged");
   a_page_wrap: assert property (store |=> addr_reg[OFS_W-1:0] == $past(addr_reg[OFS_W-1:0]) + 6'h01 &&
                                 addr_reg[ADDR_W-1:OFS_W] == $past(addr_reg[ADDR_W-1:OFS_W]))
      else $error("offset did not advance within page");
   a_start_aborts: assert property (start_seen && st_reg != ST_BUSY |=> st_reg == ST_DEV && mask_reg == '0)
      else $error("start did not abort command");
   a_lock_sets: assert property (commit && lock_pend_reg |=> ##1 id_locked_o)
      else $error("lock command not applied");
endmodule
`default_nettype wire

// >>> tb/sebw_master.sv
`timescale 1ns/100ps
`default_nettype none
module sebw_master (
   // Bus lines, released lines float high.
   output logic      scl_o,
   output logic      sda_rel_o,
   input  wire logic sda_i
);
   // SCL starts high and is high again after each Stop; a frame left without a Stop leaves it low.
   initial begin
      scl_o = 1'b1;
      sda_rel_o = 1'b1;
   end
   ////////////////////////////////////////
   // Start, also a repeated start from a low clock phase.
   task automatic start();
      sda_rel_o = 1'b1;
      #31 scl_o = 1'b1;
      #31 sda_rel_o = 1'b0;
      #31 scl_o = 1'b0;
   endtask
   // One bit slot; data moves only while SCL is low so it never fakes a Start.
   task automatic clock_bit(input logic b, output logic s);
      #31 sda_rel_o = b;
      #32 scl_o = 1'b1;
      #31 s = sda_i;
      #31 scl_o = 1'b0;
   endtask
   // Eight bits most significant first, then a released ninth slot.
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
      clock_bit(1'b1, s);
      ack = ~s;
   endtask
   // Stop from a low clock phase.
   task automatic stop();
      #31 sda_rel_o = 1'b0;
      #32 scl_o = 1'b1;
      #31 sda_rel_o = 1'b1;
      #62;
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_serial_eeprom_bus_slave_write.sv
`timescale 1ns/100ps
`default_nettype none
module tb_serial_eeprom_bus_slave_write;
   import sebw_pkg::*;
   logic        clk = 1'b0;
   logic        reset, scl, sda_rel, sda_w, sda_o, sda_oe_n, wp, prog_ready;
   logic        prog_valid, prog_id, busy, id_locked;
   logic [2:0]  cs;
   logic [11:0] prog_group;
   logic [31:0] prog_data, md;
   logic [3:0]  prog_mask;
   logic [15:0] addr_cnt;
   logic [48:0] words[$];
   int          error_cnt = 0;
   int          checked = 0;
   int          cycles = 0;
   ////////////////////////////////////////
   // Open-drain wire with pull-up.
   assign sda_w = sda_rel & (sda_oe_n | sda_o);
   always #2 clk = ~clk;
   sebw_master m (.scl_o(scl), .sda_rel_o(sda_rel), .sda_i(sda_w));
   sebw_slave #(.PROG_CYCLES(400)) dut (.clk_i(clk), .reset_i(reset), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .chip_select_strap_hi_i(cs[2]), .chip_select_strap_mid_i(cs[1]),
      .chip_select_strap_lo_i(cs[0]), .write_protect_input_i(wp), .prog_valid_o(prog_valid),
      .prog_ready_i(prog_ready), .prog_id_page_o(prog_id), .prog_group_o(prog_group),
      .prog_data_o(prog_data), .prog_mask_o(prog_mask), .busy_o(busy), .id_locked_o(id_locked),
      .addr_counter_o(addr_cnt));
   // Collect accepted words; unmasked bytes hold old contents and are zeroed.
   always @(posedge clk) begin
      if (prog_valid && prog_ready) begin
         for (int b = 0; b < 4; b++) md[8*b+:8] = prog_mask[b] ? prog_data[8*b+:8] : 8'h00;
         words.push_back({prog_id, prog_group, md, prog_mask});
      end
   end
   // A hang ends the run as a failure.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         error_cnt++;
         test_done();
      end
   end
   ////////////////////////////////////////
   task automatic test_done();
      if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp_bit(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask
   task automatic cmp_word(input logic [48:0] got, input logic [48:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h", $time, what, got);
      end
   endtask
   // Start then n bytes from the top of d; ea holds the expected acks.
   task automatic frame(input logic [47:0] d, input int n, input logic [5:0] ea);
      logic a;
      m.start();
      for (int i = 0; i < n; i++) begin
         m.send_byte(d[47-8*i -: 8], a);
         cmp_bit(a, ea[5-i], "acknowledge");
      end
   endtask
   // Bounded wait for the programming interval to end.
   task automatic wait_idle();
      for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge clk);
      cmp_bit(busy, 1'b0, "busy never ended");
   endtask
   task automatic settle();
      repeat (40) @(posedge clk);
   endtask
   ////////////////////////////////////////
   // Only the strap value answers; a read select is acknowledged too.
   task automatic sc_select();
      for (int s = 0; s < 8; s++) begin
         frame({4'hA, s[2:0], 1'b0, 40'h0}, 1, {s == 5, 5'h00});
         m.stop();
      end
      frame({8'hAB, 40'h0}, 1, 6'h20);
      m.stop();
   endtask
   // Page write across the page end with the array stalled, polled while busy.
   task automatic sc_wrap();
      @(posedge clk);
      prog_ready <= 1'b0;
      frame({8'hAA, 8'hC1, 8'h7E, 8'h11, 8'h22, 8'h33}, 6, 6'h3F);
      m.stop();
      repeat (20) @(posedge clk);
      cmp_bit(busy, 1'b1, "no write cycle");
      frame({8'hAA, 40'h0}, 1, 6'h00);
      wait_idle();
      frame({8'hAA, 40'h0}, 1, 6'h20);
      m.stop();
      cmp_bit(prog_valid, 1'b1, "word dropped while stalled");
      @(posedge clk);
      prog_ready <= 1'b1;
      settle();
      cmp_word(words.pop_front(), {1'b0, 12'h050, 32'h0000_0033, 4'h1}, "wrapped group");
      cmp_word(words.pop_front(), {1'b0, 12'h05F, 32'h2211_0000, 4'hC}, "last group");
      cmp_bit(addr_cnt[13:0] === 14'h0141, 1'b1, "address counter");
   endtask
   // Protected write: address acked, data refused, nothing programmed.
   task automatic sc_protect();
      @(posedge clk);
      wp <= 1'b1;
      frame({8'hAA, 8'h00, 8'h10, 8'h5A, 16'h0}, 4, 6'h38);
      m.stop();
      settle();
      cmp_bit(busy, 1'b0, "protected write ran");
      @(posedge clk);
      wp <= 1'b0;
   endtask
   // Stop after the address, and a Start after data, both run nothing.
   task automatic sc_abort();
      frame({8'hAA, 8'h00, 8'h10, 24'h0}, 3, 6'h38);
      m.stop();
      settle();
      cmp_bit(busy, 1'b0, "stop after address");
      frame({8'hAA, 8'h00, 8'h10, 8'h5A, 16'h0}, 4, 6'h3C);
      m.start();
      m.stop();
      settle();
      cmp_bit(busy, 1'b0, "aborted write ran");
      cmp_bit(words.size() == 0, 1'b1, "stray program word");
   endtask
   // Identification byte, a lock without and with data bit one, then refusal.
   task automatic sc_idpage();
      frame({8'hBA, 8'h00, 8'h05, 8'h77, 16'h0}, 4, 6'h3C);
      m.stop();
      settle();
      wait_idle();
      cmp_word(words.pop_front(), {1'b1, 12'h001, 32'h0000_7700, 4'h2}, "id byte");
      frame({8'hBA, 8'h04, 8'h00, 8'hFD, 16'h0}, 4, 6'h3C);
      m.stop();
      settle();
      wait_idle();
      cmp_bit(id_locked, 1'b0, "locked without bit one");
      frame({8'hBA, 8'h04, 8'h00, 8'h02, 16'h0}, 4, 6'h3C);
      m.stop();
      settle();
      wait_idle();
      cmp_bit(id_locked, 1'b1, "lock missing");
      frame({8'hBA, 8'h00, 8'h05, 8'h77, 16'h0}, 4, 6'h38);
      m.stop();
      settle();
      cmp_bit(words.size() == 0, 1'b1, "locked page written");
   endtask
   ////////////////////////////////////////
   // Main sequence.
   initial begin
      reset <= 1'b1;
      cs <= 3'b101;
      wp <= 1'b0;
      prog_ready <= 1'b1;
      repeat (6) @(posedge clk);
      cmp_bit(sda_oe_n, 1'b1, "bus driven in reset");
      reset <= 1'b0;
      repeat (10) @(posedge clk);
      sc_select();
      sc_wrap();
      sc_protect();
      sc_abort();
      sc_idpage();
      test_done();
   end
endmodule
`default_nettype wire
